// file: hw/sxd_dma.sv
// Six-channel serial DMA engine with AXI4-Lite registers.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module sxd_dma (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// AXI4-Lite register slave
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	// System memory port
	output logic              mem_req,
	output logic              mem_we,
	output logic [31:0]       mem_addr,
	output logic [31:0]       mem_wdata,
	input  wire logic         mem_ack,
	input  wire logic [31:0]  mem_rdata,
	// Serial device port
	input  wire logic [15:0]  dev_req,
	output logic              dev_strb,
	output logic              dev_we,
	output logic [31:0]       dev_addr,
	output logic [3:0]        dev_sel,
	output logic [15:0]       dev_wdata,
	input  wire logic         dev_ack,
	input  wire logic [15:0]  dev_rdata,
	// Per-device programmed I/O select
	output logic [15:0]       pio_mode
);
	localparam int NCH = sxd_pkg::NUM_CH;
	localparam int CW = sxd_pkg::CTL_W;

	typedef struct packed {
		sxd_pkg::sxd_state_t      st;
		logic [2:0]               ch;
		logic [3:0]               beat;
		logic [2:0]               widx;
		logic [3:0]               ack_cnt;
		logic [3:0][31:0]         buff;
		logic [NCH-1:0][31:0]     ddar;
		logic [NCH-1:0][CW-1:0]   ctl;
		logic [NCH-1:0][31:0]     sa;
		logic [NCH-1:0][31:0]     ca;
		logic [NCH-1:0][31:0]     sb;
		logic [NCH-1:0][31:0]     cb;
		logic [15:0]              pio;
		logic                     awready;
		logic                     wready;
		logic [7:0]               awaddr;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     arready;
		logic                     rvalid;
		logic [31:0]              rdata;
		logic [1:0]               rresp;
		logic                     mem_req;
		logic                     mem_we;
		logic [31:0]              mem_addr;
		logic [31:0]              mem_wdata;
		logic                     dev_strb;
		logic                     dev_we;
		logic [31:0]              dev_addr;
		logic [3:0]               dev_sel;
		logic [15:0]              dev_wdata;
	} sxd_regs_t;

	sxd_regs_t             q;
	sxd_regs_t             next_q;
	logic [NCH-1:0]        elig;
	logic [2:0]            gnt_idx;
	logic                  gnt_valid;
	logic [31:0]           cur_ddar;
	logic                  cur_act;
	logic                  cur_chain;
	logic [3:0]            beats;
	logic [4:0]            bb;
	logic [2:0]            nwords;
	logic [1:0]            wsel;
	logic [1:0]            lane;
	logic                  last_beat;
	logic [31:0]           cur_addr;
	logic [31:0]           cur_cnt;
	logic [31:0]           new_cnt;
	logic [15:0]           lane_ext;
	logic [31:0]           lane_merged;
	logic [2:0]            wch;
	logic [4:0]            wofs;
	logic [2:0]            rch;
	logic [4:0]            rofs;
	logic [31:0]           rd_word;
	logic                  rd_ok;
	logic                  wr_ok;
	logic [31:0]           pio_wr;

	// Eligibility: running, buffer armed, device asking, not on PIO.
	for (genvar i = 0; i < NCH; i++) begin : g_elig
		logic [3:0] ds;
		assign ds = q.ddar[i][sxd_pkg::DS_HI:sxd_pkg::DS_LO];
		assign elig[i] = q.ctl[i][sxd_pkg::CTL_RUN]
			&& (q.ctl[i][sxd_pkg::CTL_ACT] ? q.ctl[i][sxd_pkg::CTL_RDY_B]
				: q.ctl[i][sxd_pkg::CTL_RDY_A])
			&& dev_req[ds] && !q.pio[ds];
	end

	sxd_prio_arb u_arb (
		.req   (elig),
		.idx   (gnt_idx),
		.valid (gnt_valid)
	);

	// Burst shape of the channel being served.
	assign cur_ddar = q.ddar[q.ch];
	assign cur_act = q.ctl[q.ch][sxd_pkg::CTL_ACT];
	assign cur_chain = q.ctl[q.ch][sxd_pkg::CTL_CHAIN];
	assign beats = cur_ddar[sxd_pkg::DDAR_BS] ? sxd_pkg::BEATS_LONG
		: sxd_pkg::BEATS_SHORT;
	assign bb = cur_ddar[sxd_pkg::DDAR_DW] ? {beats, 1'b0} : {1'b0, beats};
	assign nwords = bb[4:2];
	assign wsel = cur_ddar[sxd_pkg::DDAR_DW] ? q.beat[2:1] : q.beat[3:2];
	assign lane = cur_ddar[sxd_pkg::DDAR_DW] ? {1'b0, q.beat[0]}
		: q.beat[1:0];
	assign last_beat = (q.beat == beats - 4'h1);
	assign cur_addr = cur_act ? q.sb[q.ch] : q.sa[q.ch];
	assign cur_cnt = cur_act ? q.cb[q.ch] : q.ca[q.ch];
	assign new_cnt = (cur_cnt > {27'h0, bb}) ? cur_cnt - {27'h0, bb}
		: sxd_pkg::REG_RESET;

	sxd_lane u_lane (
		.word   (q.buff[wsel]),
		.lane   (lane),
		.half   (cur_ddar[sxd_pkg::DDAR_DW]),
		.big    (cur_ddar[sxd_pkg::DDAR_END]),
		.din    (dev_rdata),
		.ext    (lane_ext),
		.merged (lane_merged)
	);

	// Register address decode for both AXI paths.
	assign wch = q.awaddr[7:sxd_pkg::CH_SHIFT];
	assign wofs = q.awaddr[sxd_pkg::CH_SHIFT-1:0];
	assign rch = s_axi_araddr[7:sxd_pkg::CH_SHIFT];
	assign rofs = s_axi_araddr[sxd_pkg::CH_SHIFT-1:0];
	assign wr_ok = (q.awaddr == sxd_pkg::OFS_PIO) || ((wch < 3'(NCH))
		&& (wofs <= sxd_pkg::OFS_CB) && (wofs[1:0] == 2'h0));

	// Read data mux; unmapped addresses answer SLVERR with zero data.
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b0;
		if (s_axi_araddr == sxd_pkg::OFS_PIO) begin
			rd_word = {16'h0000, q.pio};
			rd_ok = 1'b1;
		end else if (rch < 3'(NCH) && rofs[1:0] == 2'h0) begin
			rd_ok = 1'b1;
			case (rofs)
				sxd_pkg::OFS_DEV: rd_word = q.ddar[rch];
				sxd_pkg::OFS_CTL: rd_word = {25'h0, q.ctl[rch]};
				sxd_pkg::OFS_SA: rd_word = q.sa[rch];
				sxd_pkg::OFS_CA: rd_word = q.ca[rch];
				sxd_pkg::OFS_SB: rd_word = q.sb[rch];
				sxd_pkg::OFS_CB: rd_word = q.cb[rch];
				default: rd_ok = 1'b0;
			endcase
		end
	end

	// Byte-enable merge of an AXI write into an old register value.
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Byte-merged view of a write to the programmed I/O select.
	assign pio_wr = wmerge({16'h0000, q.pio}, q.wdata, q.wstrb);

	// Next state: bus slave first, then the engine, so hardware sets win.
	always_comb begin
		next_q = q;
		// Write address and data are taken independently.
		if (s_axi_awvalid && q.awready) begin
			next_q.awready = 1'b0;
			next_q.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			next_q.wready = 1'b0;
			next_q.wdata = s_axi_wdata;
			next_q.wstrb = s_axi_wstrb;
		end
		if (!q.awready && !q.wready && !q.bvalid) begin
			next_q.bvalid = 1'b1;
			next_q.bresp = wr_ok ? sxd_pkg::RESP_OKAY : sxd_pkg::RESP_SLVERR;
			if (q.awaddr == sxd_pkg::OFS_PIO) begin
				next_q.pio = pio_wr[15:0] & ~sxd_pkg::USB_DEV_MASK;
			end else if (wr_ok) begin
				case (wofs)
					sxd_pkg::OFS_DEV: begin
						if (!q.ctl[wch][sxd_pkg::CTL_RUN]) begin
							next_q.ddar[wch] = wmerge(q.ddar[wch], q.wdata,
								q.wstrb);
						end
					end
					sxd_pkg::OFS_CTL: begin
						next_q.ctl[wch][3:0] = q.wdata[3:0];
						if (!q.ctl[wch][sxd_pkg::CTL_RUN]) begin
							next_q.ctl[wch][sxd_pkg::CTL_ACT] =
								q.wdata[sxd_pkg::CTL_ACT];
						end
						if (q.wdata[sxd_pkg::CTL_DONE_A]) begin
							next_q.ctl[wch][sxd_pkg::CTL_DONE_A] = 1'b0;
						end
						if (q.wdata[sxd_pkg::CTL_DONE_B]) begin
							next_q.ctl[wch][sxd_pkg::CTL_DONE_B] = 1'b0;
						end
					end
					sxd_pkg::OFS_SA: next_q.sa[wch] = wmerge(q.sa[wch],
						q.wdata, q.wstrb);
					sxd_pkg::OFS_CA: next_q.ca[wch] = wmerge(q.ca[wch],
						q.wdata, q.wstrb);
					sxd_pkg::OFS_SB: next_q.sb[wch] = wmerge(q.sb[wch],
						q.wdata, q.wstrb);
					sxd_pkg::OFS_CB: next_q.cb[wch] = wmerge(q.cb[wch],
						q.wdata, q.wstrb);
					default: next_q.bresp = sxd_pkg::RESP_SLVERR;
				endcase
			end
		end
		if (q.bvalid && s_axi_bready) begin
			next_q.bvalid = 1'b0;
			next_q.awready = 1'b1;
			next_q.wready = 1'b1;
		end
		// Read channel answers one cycle after the address is taken.
		if (s_axi_arvalid && q.arready) begin
			next_q.arready = 1'b0;
			next_q.rvalid = 1'b1;
			next_q.rdata = rd_word;
			next_q.rresp = rd_ok ? sxd_pkg::RESP_OKAY : sxd_pkg::RESP_SLVERR;
		end else if (q.rvalid && s_axi_rready) begin
			next_q.rvalid = 1'b0;
			next_q.arready = 1'b1;
		end
		if (q.dev_strb && dev_ack) begin
			next_q.ack_cnt = q.ack_cnt + 4'h1;
		end
		// Transfer engine.
		case (q.st)
			sxd_pkg::ST_IDLE: begin
				next_q.ack_cnt = 4'h0;
				if (gnt_valid) begin
					next_q.ch = gnt_idx;
					next_q.beat = 4'h0;
					next_q.widx = 3'h0;
					next_q.dev_addr = sxd_pkg::sxd_port_addr(q.ddar[gnt_idx]);
					next_q.dev_sel = q.ddar[gnt_idx][sxd_pkg::DS_HI:sxd_pkg::DS_LO];
					next_q.st = q.ddar[gnt_idx][sxd_pkg::DDAR_DIR]
						? sxd_pkg::ST_DRD : sxd_pkg::ST_MRD;
				end
			end
			sxd_pkg::ST_MRD, sxd_pkg::ST_MWR: begin
				if (!q.mem_req) begin
					next_q.mem_req = 1'b1;
					next_q.mem_we = (q.st == sxd_pkg::ST_MWR);
					next_q.mem_addr = cur_addr + {27'h0, q.widx, 2'h0};
					next_q.mem_wdata = q.buff[q.widx[1:0]];
				end else if (mem_ack) begin
					next_q.mem_req = 1'b0;
					next_q.widx = q.widx + 3'h1;
					if (q.st == sxd_pkg::ST_MRD) begin
						next_q.buff[q.widx[1:0]] = mem_rdata;
					end
					if (q.widx == nwords - 3'h1) begin
						next_q.widx = 3'h0;
						next_q.st = (q.st == sxd_pkg::ST_MRD)
							? sxd_pkg::ST_DWR : sxd_pkg::ST_FIN;
					end
				end
			end
			sxd_pkg::ST_DWR, sxd_pkg::ST_DRD: begin
				if (!q.dev_strb) begin
					next_q.dev_strb = 1'b1;
					next_q.dev_we = (q.st == sxd_pkg::ST_DWR);
					next_q.dev_wdata = lane_ext;
				end else if (dev_ack) begin
					next_q.dev_strb = 1'b0;
					next_q.beat = q.beat + 4'h1;
					if (q.st == sxd_pkg::ST_DRD) begin
						next_q.buff[wsel] = lane_merged;
					end
					if (last_beat) begin
						next_q.st = (q.st == sxd_pkg::ST_DWR)
							? sxd_pkg::ST_FIN : sxd_pkg::ST_MWR;
					end
				end
			end
			sxd_pkg::ST_FIN: begin
				next_q.st = sxd_pkg::ST_IDLE;
				if (cur_act) begin
					next_q.sb[q.ch] = cur_addr + {27'h0, bb};
					next_q.cb[q.ch] = new_cnt;
				end else begin
					next_q.sa[q.ch] = cur_addr + {27'h0, bb};
					next_q.ca[q.ch] = new_cnt;
				end
				if (new_cnt == sxd_pkg::REG_RESET) begin
					next_q.ctl[q.ch][cur_act ? sxd_pkg::CTL_RDY_B
						: sxd_pkg::CTL_RDY_A] = 1'b0;
					next_q.ctl[q.ch][cur_act ? sxd_pkg::CTL_DONE_B
						: sxd_pkg::CTL_DONE_A] = 1'b1;
					if (cur_chain) begin
						next_q.ctl[q.ch][sxd_pkg::CTL_ACT] = ~cur_act;
					end
				end
			end
			default: next_q.st = sxd_pkg::ST_IDLE;
		endcase
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.st <= sxd_pkg::ST_IDLE;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// Outputs straight from the state register.
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign mem_req = q.mem_req;
	assign mem_we = q.mem_we;
	assign mem_addr = q.mem_addr;
	assign mem_wdata = q.mem_wdata;
	assign dev_strb = q.dev_strb;
	assign dev_we = q.dev_we;
	assign dev_addr = q.dev_addr;
	assign dev_sel = q.dev_sel;
	assign dev_wdata = q.dev_wdata;
	assign pio_mode = q.pio;

	// Checks on the engine and register behaviour.
	default clocking cb_main @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_ddar_write_locked;
		!q.awready && !q.wready && !q.bvalid && wr_ok
			&& wofs == sxd_pkg::OFS_DEV && q.ctl[wch][sxd_pkg::CTL_RUN];
	endsequence
	sequence s_last_chained;
		q.st == sxd_pkg::ST_FIN && new_cnt == sxd_pkg::REG_RESET && cur_chain;
	endsequence

	a_lowest_wins: assert property (
		q.st == sxd_pkg::ST_IDLE && elig[0] |=> q.ch == 3'h0
			&& q.st != sxd_pkg::ST_IDLE)
		else $error("channel zero lost arbitration");
	a_prio_grant: assert property (
		q.st == sxd_pkg::ST_IDLE && gnt_valid |=> q.ch == $past(gnt_idx))
		else $error("served channel differs from priority winner");
	a_burst_hold: assert property (
		q.st != sxd_pkg::ST_IDLE && q.st != sxd_pkg::ST_FIN |=> $stable(q.ch))
		else $error("channel changed inside a burst");
	a_beat_total: assert property (
		q.st == sxd_pkg::ST_FIN |-> q.ack_cnt == beats)
		else $error("burst ended with wrong beat count");
	a_byte_beats: assert property (
		q.dev_strb && q.dev_we && !cur_ddar[sxd_pkg::DDAR_DW]
			|-> q.dev_wdata[15:8] == 8'h00)
		else $error("byte beat carries upper data");
	a_dir_path: assert property (
		q.dev_strb |-> q.dev_we == !cur_ddar[sxd_pkg::DDAR_DIR])
		else $error("device beat against programmed direction");
	a_usb_dma: assert property (
		(q.pio & sxd_pkg::USB_DEV_MASK) == 16'h0000)
		else $error("USB device switched to programmed I/O");
	a_chain_next: assert property (
		s_last_chained |=> q.ctl[q.ch][sxd_pkg::CTL_ACT] != $past(cur_act)
			&& q.st == sxd_pkg::ST_IDLE)
		else $error("chained buffer did not take over");
	a_word_access: assert property (
		q.mem_req |-> q.mem_addr[1:0] == 2'h0 ##1 !q.mem_req || mem_ack
			|| $stable(q.mem_addr))
		else $error("memory access not a stable aligned word");
	a_ddar_lock: assert property (
		s_ddar_write_locked |=> $stable(q.ddar))
		else $error("device register written while running");
endmodule
`default_nettype wire

// file: hw/sxd_lane.sv
// Byte lane steering between memory words and device beats.
`timescale 1ns/1ps
`default_nettype none
module sxd_lane (
	// Word and beat position
	input  wire logic [31:0] word,
	input  wire logic [1:0]  lane,
	input  wire logic        half,
	input  wire logic        big,
	// Beat data
	input  wire logic [15:0] din,
	output logic [15:0]      ext,
	output logic [31:0]      merged
);
	logic [1:0] slot;

	// Picks the lane a beat occupies and extracts or inserts it.
	always_comb begin
		merged = word;
		ext = 16'h0000;
		if (half) begin
			slot = {1'b0, big ? ~lane[0] : lane[0]};
			ext = word[{slot[0], 4'h0} +: 16];
			merged[{slot[0], 4'h0} +: 16] = din;
		end else begin
			slot = big ? ~lane : lane;
			ext = {8'h00, word[{slot, 3'h0} +: 8]};
			merged[{slot, 3'h0} +: 8] = din[7:0];
		end
	end
endmodule
`default_nettype wire

// file: hw/sxd_pkg.sv
// Constants, types and helpers shared by the six-channel serial DMA engine.
// Functional notes
// - Six independent channels; each one may point at any serial controller.
// - Requests come by interrupt or DMA; the USB controller cannot use PIO.
// - Simultaneous requests are resolved by a fixed priority order.
// - Service goes in device bursts of byte or half-word beats.
// - Burst size and beat width come from the channel's registers.
// - A whole burst completes before the engine switches channel.
// - Pick depends on channel active, device requesting, and priority.
// - Memory to device: read words into a buffer, then write beats.
// - Device to memory: beats are packed into words by the endian bit.
// - Each channel has start address and count for buffers A and B.
// - Chained buffers: the end of one starts the other at once.
// - Control/status shows the active buffer so the other can be refilled.
// - Byte-order bit 0 means little endian memory, 1 means big endian.
// - Burst-size bit 0 gives four beats, 1 gives eight beats.
// - Direction bit 0 is memory to device, 1 is device to memory.
// - Width bit 0 gives byte beats, 1 gives half-word beats.
package sxd_pkg;
	// Structure sizes.
	localparam int NUM_CH = 6;
	localparam int CH_W = 3;
	localparam int NUM_DEV = 16;
	localparam int DS_W = 4;
	localparam int CTL_W = 7;
	localparam int BUF_WORDS = 4;

	// Register byte offsets inside one channel, channel in address bits 7:5.
	localparam int CH_SHIFT = 5;
	localparam logic [4:0] OFS_DEV = 5'h00;
	localparam logic [4:0] OFS_CTL = 5'h04;
	localparam logic [4:0] OFS_SA = 5'h08;
	localparam logic [4:0] OFS_CA = 5'h0C;
	localparam logic [4:0] OFS_SB = 5'h10;
	localparam logic [4:0] OFS_CB = 5'h14;
	localparam logic [7:0] OFS_PIO = 8'hC0;

	// Device address register fields.
	localparam int DDAR_DIR = 0;
	localparam int DDAR_END = 1;
	localparam int DDAR_BS = 2;
	localparam int DDAR_DW = 3;
	localparam int DS_LO = 4;
	localparam int DS_HI = 7;
	localparam int DA_LOW = 8;
	localparam int DA_SPLIT = 28;
	localparam int DA_TOP = 31;
	localparam logic [5:0] PORT_GAP = 6'h00;
	localparam logic [1:0] PORT_ALIGN = 2'h0;

	// Control/status register fields.
	localparam int CTL_RUN = 0;
	localparam int CTL_CHAIN = 1;
	localparam int CTL_RDY_A = 2;
	localparam int CTL_RDY_B = 3;
	localparam int CTL_DONE_A = 4;
	localparam int CTL_DONE_B = 5;
	localparam int CTL_ACT = 6;

	// Reset values and burst figures.
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [15:0] USB_DEV_MASK = 16'h0003;
	localparam logic [3:0] BEATS_SHORT = 4'h4;
	localparam logic [3:0] BEATS_LONG = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Transfer engine states.
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_MRD = 6'h02,
		ST_DWR = 6'h04,
		ST_DRD = 6'h08,
		ST_MWR = 6'h10,
		ST_FIN = 6'h20
	} sxd_state_t;

	// Rebuilds the device data port address from the partial address field.
	function automatic logic [31:0] sxd_port_addr(input logic [31:0] d);
		return {d[DA_TOP:DA_SPLIT], PORT_GAP, d[DA_SPLIT-1:DA_LOW],
			PORT_ALIGN};
	endfunction
endpackage

// file: hw/sxd_prio_arb.sv
// Fixed-priority channel picker, lowest index first.
`timescale 1ns/1ps
`default_nettype none
module sxd_prio_arb (
	// Eligible channels
	input  wire logic [sxd_pkg::NUM_CH-1:0] req,
	// Winner
	output logic [sxd_pkg::CH_W-1:0]        idx,
	output logic                            valid
);
	localparam int N = sxd_pkg::NUM_CH;
	localparam int W = sxd_pkg::CH_W;

	logic [N:0]   seen;
	logic [N-1:0] win;

	// A channel wins only when no lower channel asks.
	assign seen[0] = 1'b0;
	for (genvar i = 0; i < N; i++) begin : g_pri
		assign win[i] = req[i] & ~seen[i];
		assign seen[i+1] = seen[i] | req[i];
	end
	assign valid = seen[N];

	// Encodes the single winning bit into a channel number.
	always_comb begin
		idx = '0;
		for (int i = 0; i < N; i++) begin
			if (win[i]) begin
				idx = W'(i);
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/sxd_far_model.sv
// Memory and serial device data ports that answer the DMA engine.
`timescale 1ns/1ps
`default_nettype none
module sxd_far_model (
	// Clock and pace
	input  wire logic        aclk,
	input  wire logic        slow,
	// Memory port
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	output logic             mem_ack,
	output logic [31:0]      mem_rdata,
	// Device port
	input  wire logic        dev_strb,
	input  wire logic        dev_we,
	output logic             dev_ack,
	output logic [15:0]      dev_rdata
);
	logic [1:0]  mcnt = 2'h0;
	logic [1:0]  dcnt = 2'h0;
	logic [15:0] nrd = 16'h0000;
	logic [31:0] mword;
	assign mword = mem_addr ^ 32'hA5C3_1E69;
	// Idle data lines show the inverse so a stale value never matches.
	assign mem_rdata = (mem_ack && !mem_we) ? mword : ~mword;
	assign dev_rdata = dev_ack ? 16'hB000 + nrd : ~(16'hB000 + nrd);
	initial begin
		mem_ack = 1'b0;
		dev_ack = 1'b0;
	end
	// Each pending access is answered after none or three wait cycles.
	always @(posedge aclk) begin
		mem_ack <= 1'b0;
		dev_ack <= 1'b0;
		if (mem_req && !mem_ack) begin
			mcnt <= (mcnt == {slow, slow}) ? 2'h0 : mcnt + 2'h1;
			mem_ack <= (mcnt == {slow, slow});
		end
		if (dev_strb && !dev_ack) begin
			dcnt <= (dcnt == {slow, slow}) ? 2'h0 : dcnt + 2'h1;
			dev_ack <= (dcnt == {slow, slow});
		end
		if (dev_ack && !dev_we)
			nrd <= nrd + 16'h0001;
	end
endmodule
`default_nettype wire

// file: verification/tb_sxd_dma.sv
// Self-checking bench for the six-channel serial DMA engine.
`timescale 1ns/1ps
`default_nettype none
module tb_sxd_dma;
	logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [15:0] dev_req = 16'h0000;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata, dev_addr;
	logic        mem_req, mem_we, mem_ack, dev_strb, dev_we, dev_ack;
	logic [3:0]  dev_sel;
	logic [15:0] dev_wdata, dev_rdata, pio_mode;
	logic [33:0] qr[$];
	logic [19:0] qd[$];
	logic [63:0] qm[$];
	int          fail_count = 0, checks = 0, cyc = 0, nrd = 0;
	logic [31:0] sa, sb;
	int          e;

	sxd_dma i_sxd_dma (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_we,
		.mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .dev_req, .dev_strb,
		.dev_we, .dev_addr, .dev_sel, .dev_wdata, .dev_ack, .dev_rdata,
		.pio_mode);
	sxd_far_model i_sxd_far_model (.aclk, .slow, .mem_req, .mem_we,
		.mem_addr, .mem_ack, .mem_rdata, .dev_strb, .dev_we, .dev_ack,
		.dev_rdata);

	// Free-running 100 MHz clock.
	always #5 aclk = ~aclk;

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Register write; each channel is released once it is taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	// Register read; the expected response and data go to the queue.
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		qr.push_back(x);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	// Programs device, both buffers with one count, then control.
	task automatic arm(input int ch, input logic [31:0] dv, a, b, n, c);
		logic [7:0] base;
		base = 8'(ch * 32);
		wr(base, dv);
		wr(base + 8'h08, a);
		wr(base + 8'h0C, n);
		wr(base + 8'h10, b);
		wr(base + 8'h14, n);
		wr(base + 4, c);
	endtask

	function automatic logic [31:0] ddev(input int ds, rw, e, bs, dw);
		return 32'h8000_0A00 | (ds << 4) | (dw << 3) | (bs << 2)
			| (e << 1) | rw;
	endfunction

	// Notes the device beats of one burst read from memory at a.
	task automatic push_burst(input int ds, input logic [31:0] a,
		input int e, dw, bs);
		logic [31:0] w;
		int o;
		for (int k = 0; k < (bs ? 8 : 4); k++) begin
			o = k * (dw + 1);
			w = (a + 32'(o & ~3)) ^ 32'hA5C3_1E69;
			w = w >> (e ? (dw ? 16 : 24) - 8 * (o % 4) : 8 * (o % 4));
			qd.push_back({4'(ds), dw ? w[15:0] : {8'h00, w[7:0]}});
		end
	endtask

	// Notes memory words packed from half-word device beats.
	task automatic push_d2m(input logic [31:0] a, input int e, nw);
		logic [15:0] lo, hi;
		for (int j = 0; j < nw; j++) begin
			lo = 16'(16'hB000 + nrd);
			hi = lo + 16'h0001;
			nrd += 2;
			qm.push_back({a + 32'(4 * j), e ? {lo, hi} : {hi, lo}});
		end
	endtask

	task automatic drain();
		repeat (3000)
			if (qd.size() + qm.size() != 0)
				@(posedge aclk);
		chk(64'(qd.size() + qm.size()), 64'h0);
	endtask

	// Watches outputs and compares each read, device write and memory write with the oldest note; write responses must be OKAY.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
		if (s_axi_bvalid && s_axi_bready)
			chk(s_axi_bresp, 2'h0);
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, qr.pop_front());
		if (dev_strb && dev_ack && dev_we) begin
			chk({dev_sel, dev_wdata}, qd.pop_front());
			chk(dev_addr, 32'h8000_0028);
		end
		if (mem_req && mem_ack && mem_we)
			chk({mem_addr, mem_wdata}, qm.pop_front());
	end

	initial begin
		void'($urandom(88857));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h04, 34'h0);
		rd(8'h18, {2'h2, 32'h0});
		wr(8'hC0, 32'hFFFF);
		chk(pio_mode, 16'hFFFC);
		rd(8'hC0, 34'hFFFC);
		wr(8'hC0, 32'h0);
		$display("registers done");
		for (int i = 0; i < 3; i++) begin
			sa = $urandom & 32'h0000_FFF0;
			arm(i * 2, ddev(2 + i * 5, 0, i > 0, i == 2, i == 2), sa, sa,
				(i == 2) ? 16 : 4, 32'h5);
			push_burst(2 + i * 5, sa, i > 0, i == 2, i == 2);
			dev_req[2 + i * 5] <= 1'b1;
			drain();
			rd(8'(i * 64 + 4), 34'h11);
			rd(8'(i * 64 + 12), 34'h0);
		end
		$display("memory to device done");
		wr(8'h00, 32'h0);
		rd(8'h00, {2'h0, ddev(2, 0, 0, 0, 0)});
		sa = $urandom & 32'h0000_FFF0;
		sb = $urandom & 32'h0000_FFF0;
		e = $urandom & 1;
		slow <= 1'b1;
		arm(5, ddev(6, 1, e, 0, 1), sa, sb, 8, 32'hF);
		push_d2m(sa, e, 2);
		push_d2m(sb, e, 2);
		dev_req[6] <= 1'b1;
		drain();
		rd(8'hA4, 34'h33);
		slow <= 1'b0;
		$display("chained device to memory done");
		arm(3, ddev(10, 0, 0, 0, 0), 32'h100, 32'h100, 8, 32'h5);
		arm(1, ddev(11, 0, 0, 0, 0), 32'h200, 32'h200, 4, 32'h5);
		push_burst(10, 32'h100, 0, 0, 0);
		push_burst(11, 32'h200, 0, 0, 0);
		push_burst(10, 32'h104, 0, 0, 0);
		dev_req[10] <= 1'b1;
		do @(posedge aclk); while (!(dev_strb && dev_ack));
		dev_req[11] <= 1'b1;
		drain();
		dev_req <= 16'h0000;
		$display("priority done");
		end_sim();
	end
endmodule
`default_nettype wire
